// [hdl/sarcs_map.svh]
/*
  constants of the successive-approximation conversion sequencer: code widths,
  fixed codes, step and conversion counts, oscillator and hold timing.
  assumes ref_clk at 100 MHz and is included by its bare name.
*/
`ifndef SARCS_MAP_SVH
`define SARCS_MAP_SVH

`define SARCS_NBITS 12
`define SARCS_MSB_IDX 4'hB
`define SARCS_HALF_SCALE 12'h800
`define SARCS_ALL_ONES 12'hFFF
`define SARCS_ALL_ZEROS 12'h000

// master ticks per internal step and per conversion
`define SARCS_PHASE_LAST 2'h3
`define SARCS_CONV_TICKS 49
`define SARCS_CONV_LAST 6'h30

// hold may rise one master period plus this much after its fall
`define SARCS_REF_PERIOD_NS 10
`define SARCS_HOLD_EXTRA_NS 50
`define SARCS_HOLD_EXTRA_CYC ((`SARCS_HOLD_EXTRA_NS + `SARCS_REF_PERIOD_NS - 1) / `SARCS_REF_PERIOD_NS)

// internal oscillator as a divider of ref_clk, and the pin-low detect time
`define SARCS_OSC_LAST 8'h18
`define SARCS_PIN_LOW_LAST 8'hC8

// calibration trim words
`define SARCS_TRIM_W 6
`define SARCS_TRIM_DEPTH 12
`define SARCS_TRIM_MID 6'h20
`define SARCS_TRIM_MAX 6'h3F
`define SARCS_TRIM_MIN 6'h00

`endif

// [hdl/sarcs_pkg.sv]
/*
  types of the conversion sequencer.
  assumes nothing beyond a SystemVerilog compiler.
*/
package sarcs_pkg;

  typedef enum logic [1:0] {
    SARCS_TRACK = 2'b00,
    SARCS_ALIGN = 2'b01,
    SARCS_CONV = 2'b10,
    SARCS_CAL = 2'b11
  } sarcs_state_t;

endpackage : sarcs_pkg

// [hdl/sarcs_trim_mem.sv]
/*
  trim word memory of the capacitor bit weights, one word per bit.
  assumes one write or read per cycle; read data arrive one cycle after the address.
*/
`timescale 1ns/1ns
`include "sarcs_map.svh"

module sarcs_trim_mem (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [3:0] addr,
  input wire logic wr_en,
  input wire logic [5:0] wr_data,
  output logic [5:0] rd_data_ff
);

  logic [5:0] mem_ff [0:`SARCS_TRIM_DEPTH-1];

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      for (int i = 0; i < `SARCS_TRIM_DEPTH; i++) begin
        mem_ff[i] <= `SARCS_TRIM_MID;
      end
    end else if (wr_en) begin
      mem_ff[addr] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rd_data_ff <= `SARCS_TRIM_MID;
    end else begin
      rd_data_ff <= mem_ff[addr];
    end
  end

endmodule : sarcs_trim_mem

// [hdl/sarcs_seq.sv]
/*
  sequencer of a 12-bit successive-approximation converter: master clock select,
  hold edge capture, bit-by-bit trial code, saturation, self-calibration trim loop.
  assumes comparator and range flags are synchronous to ref_clk and settle within
  one master tick of a trial code change.
*/
`timescale 1ns/1ns
`include "sarcs_map.svh"

module sarcs_seq
  import sarcs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic master_clock_pin,
  input wire logic hold_n,
  input wire logic cmp_below,
  input wire logic ain_over_ref,
  input wire logic ain_under_range,
  input wire logic bipolar_mode,
  input wire logic cal_start,
  input wire logic cal_cmp_heavy,
  output logic [11:0] trial_code_ff,
  output logic [11:0] result_code_ff,
  output logic result_valid_ff,
  output logic tracking_ff,
  output logic converting_ff,
  output logic calibrating_ff,
  output logic osc_internal_ff,
  output logic msb_to_ref_ff,
  output logic [3:0] cal_bit_ff,
  output logic [5:0] cal_trim_ff
);

  function automatic logic [11:0] sarcs_trial_step(input logic [11:0] code, input logic [3:0] idx,
                                                   input logic below);
    logic [11:0] r;
    r = code;
    if (below) begin
      r[idx] = 1'b0;
    end
    if (idx != 4'h0) begin
      r[idx - 4'h1] = 1'b1;
    end
    return r;
  endfunction : sarcs_trial_step

  sarcs_state_t state_ff, nxt_state;
  logic pin_d_ff, hold_d_ff, sat_hi_ff, sat_lo_ff, cal_first_ff, cal_dir_ff;
  logic [7:0] low_cnt_ff, osc_cnt_ff;
  logic [1:0] phase_ff;
  logic [3:0] bit_idx_ff;
  logic [5:0] conv_cnt_ff;
  logic [5:0] trim_rd;

  // clock pin low long enough means no external clock is running
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pin_d_ff <= 1'b0;
      low_cnt_ff <= 8'h00;
      osc_internal_ff <= 1'b0;
    end else begin
      pin_d_ff <= master_clock_pin;
      low_cnt_ff <= master_clock_pin ? 8'h00 : (low_cnt_ff == `SARCS_PIN_LOW_LAST ? low_cnt_ff : low_cnt_ff + 8'h01);
      osc_internal_ff <= !master_clock_pin && (low_cnt_ff == `SARCS_PIN_LOW_LAST);
    end
  end

  wire osc_tick = (osc_cnt_ff == `SARCS_OSC_LAST);
  wire ext_tick = master_clock_pin && !pin_d_ff;
  wire mclk_tick = osc_internal_ff ? osc_tick : ext_tick;
  wire phase_tick = mclk_tick && (phase_ff == `SARCS_PHASE_LAST);
  // sampling on the master tick is what lets hold rise one master period later
  wire hold_fall = mclk_tick && hold_d_ff && !hold_n;
  wire conv_start = (state_ff == SARCS_ALIGN) && phase_tick;
  wire conv_done = (state_ff == SARCS_CONV) && mclk_tick && (conv_cnt_ff == `SARCS_CONV_LAST);
  wire conv_decide = (state_ff == SARCS_CONV) && phase_tick;
  wire cal_step = (state_ff == SARCS_CAL) && phase_tick;
  wire trim_at_limit = cal_cmp_heavy ? (trim_rd == `SARCS_TRIM_MIN) : (trim_rd == `SARCS_TRIM_MAX);
  wire cal_balanced = trim_at_limit || (!cal_first_ff && (cal_dir_ff != cal_cmp_heavy));
  wire cal_wr = cal_step && !cal_balanced;
  wire [5:0] cal_wdata = cal_cmp_heavy ? trim_rd - 6'h01 : trim_rd + 6'h01;
  wire cal_done = cal_step && cal_balanced && (cal_bit_ff == `SARCS_MSB_IDX);
  wire [11:0] final_code = sat_hi_ff ? `SARCS_ALL_ONES : (sat_lo_ff ? `SARCS_ALL_ZEROS : trial_code_ff);

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      osc_cnt_ff <= 8'h00;
      phase_ff <= 2'h0;
      hold_d_ff <= 1'b1;
    end else begin
      osc_cnt_ff <= osc_tick ? 8'h00 : osc_cnt_ff + 8'h01;
      if (mclk_tick) begin
        phase_ff <= phase_ff + 2'h1;
        hold_d_ff <= hold_n;
      end
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SARCS_TRACK: begin
        if (hold_fall) begin
          nxt_state = SARCS_ALIGN;
        end else if (cal_start) begin
          nxt_state = SARCS_CAL;
        end
      end
      SARCS_ALIGN: begin
        if (phase_tick) begin
          nxt_state = SARCS_CONV;
        end
      end
      SARCS_CONV: begin
        if (conv_done) begin
          nxt_state = SARCS_TRACK;
        end
      end
      SARCS_CAL: begin
        if (cal_done) begin
          nxt_state = SARCS_TRACK;
        end
      end
      default: nxt_state = SARCS_TRACK;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_ff <= SARCS_TRACK;
      tracking_ff <= 1'b1;
      converting_ff <= 1'b0;
      calibrating_ff <= 1'b0;
      msb_to_ref_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      tracking_ff <= (nxt_state == SARCS_TRACK);
      converting_ff <= (nxt_state == SARCS_ALIGN) || (nxt_state == SARCS_CONV);
      calibrating_ff <= (nxt_state == SARCS_CAL);
      // top capacitor on the reference while tracking doubles and offsets the range
      msb_to_ref_ff <= bipolar_mode && (nxt_state == SARCS_TRACK);
    end
  end

  // range flags are frozen at the hold edge, so later input moves have no effect
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sat_hi_ff <= 1'b0;
      sat_lo_ff <= 1'b0;
    end else if ((state_ff == SARCS_TRACK) && hold_fall) begin
      sat_hi_ff <= ain_over_ref;
      sat_lo_ff <= ain_under_range && !ain_over_ref;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      trial_code_ff <= `SARCS_HALF_SCALE;
      bit_idx_ff <= `SARCS_MSB_IDX;
      conv_cnt_ff <= 6'h00;
    end else if (conv_start) begin
      trial_code_ff <= `SARCS_HALF_SCALE;
      bit_idx_ff <= `SARCS_MSB_IDX;
      conv_cnt_ff <= 6'h00;
    end else if ((state_ff == SARCS_CONV) && mclk_tick) begin
      conv_cnt_ff <= conv_cnt_ff + 6'h01;
      if (conv_decide) begin
        trial_code_ff <= sarcs_trial_step(trial_code_ff, bit_idx_ff, cmp_below);
        bit_idx_ff <= (bit_idx_ff == 4'h0) ? 4'h0 : bit_idx_ff - 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      result_code_ff <= `SARCS_ALL_ZEROS;
      result_valid_ff <= 1'b0;
    end else begin
      result_valid_ff <= conv_done;
      if (conv_done) begin
        result_code_ff <= final_code;
      end
    end
  end

  // trim walks one step per internal step until the comparator flips direction or the trim reaches its limit
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cal_bit_ff <= 4'h0;
      cal_first_ff <= 1'b1;
      cal_dir_ff <= 1'b0;
      cal_trim_ff <= `SARCS_TRIM_MID;
    end else begin
      cal_trim_ff <= trim_rd;
      if ((state_ff == SARCS_TRACK) && !hold_fall && cal_start) begin
        cal_bit_ff <= 4'h0;
        cal_first_ff <= 1'b1;
      end else if (cal_step && cal_balanced) begin
        cal_bit_ff <= cal_done ? 4'h0 : cal_bit_ff + 4'h1;
        cal_first_ff <= 1'b1;
      end else if (cal_step) begin
        cal_dir_ff <= cal_cmp_heavy;
        cal_first_ff <= 1'b0;
      end
    end
  end

  sarcs_trim_mem u_trim (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .addr(cal_bit_ff),
    .wr_en(cal_wr),
    .wr_data(cal_wdata),
    .rd_data_ff(trim_rd)
  );

  // master ticks since conversion start, read only by the checks
  logic [6:0] chk_ticks_ff;
  always_ff @(posedge ref_clk) begin
    if (!nrst || conv_start) begin
      chk_ticks_ff <= 7'h00;
    end else if ((state_ff == SARCS_CONV) && mclk_tick) begin
      chk_ticks_ff <= chk_ticks_ff + 7'h01;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_half_scale_start: assert property (conv_start |=> trial_code_ff == `SARCS_HALF_SCALE && converting_ff)
    else $error("conversion did not start at half scale");
  a_bit_clear: assert property (conv_decide && cmp_below |=> !trial_code_ff[$past(bit_idx_ff)])
    else $error("bit under test not cleared");
  a_bit_keep: assert property (conv_decide && !cmp_below && bit_idx_ff != 4'h0
                               |=> trial_code_ff[$past(bit_idx_ff)] && trial_code_ff[$past(bit_idx_ff) - 4'h1])
    else $error("bit under test not kept or next bit not set");
  a_result_trial: assert property (result_valid_ff && !sat_hi_ff && !sat_lo_ff |-> result_code_ff == trial_code_ff)
    else $error("result differs from final trial code");
  a_conv_length: assert property (result_valid_ff |-> chk_ticks_ff == 7'h31)
    else $error("conversion not 49 master ticks");
  a_sat_high: assert property (result_valid_ff && sat_hi_ff |-> result_code_ff == `SARCS_ALL_ONES)
    else $error("over range did not give all ones");
  a_sat_low: assert property (result_valid_ff && sat_lo_ff && !sat_hi_ff |-> result_code_ff == `SARCS_ALL_ZEROS)
    else $error("under range did not give all zeros");
  a_hold_start: assert property (state_ff == SARCS_TRACK && hold_fall |=> !tracking_ff ##0 converting_ff)
    else $error("hold fall did not start conversion");
  a_auto_track: assert property (conv_done |=> tracking_ff && result_valid_ff ##1 !result_valid_ff)
    else $error("no return to tracking after conversion");
  a_idle_track: assert property (!converting_ff && !calibrating_ff |-> tracking_ff)
    else $error("idle but not tracking");
  a_held_flags: assert property (state_ff == SARCS_CONV |=> $stable(sat_hi_ff) && $stable(sat_lo_ff))
    else $error("held range flags changed in conversion");
  a_align_bound: assert property ($rose(state_ff == SARCS_ALIGN) && mclk_tick == 1'b0
                                  |-> ##[1:400] state_ff != SARCS_ALIGN)
    else $error("alignment took too long");
  a_pin_clock: assert property (master_clock_pin |=> !osc_internal_ff)
    else $error("internal oscillator kept while pin clocks");
  a_trim_step: assert property (cal_wr && cal_cmp_heavy |-> ##2 trim_rd == $past(trim_rd, 2) - 6'h01)
    else $error("heavy bit weight not trimmed down");
  a_phase_four: assert property (conv_decide |-> phase_ff == `SARCS_PHASE_LAST && conv_cnt_ff[1:0] == 2'h3)
    else $error("step not on the divide-by-four clock");
  a_ignore_hold: assert property (state_ff == SARCS_CONV && hold_fall && !conv_done |=> state_ff == SARCS_CONV)
    else $error("hold fall disturbed conversion");

  c_conv_done: cover property (result_valid_ff && !sat_hi_ff && !sat_lo_ff);
  c_sat_hi: cover property (result_valid_ff && sat_hi_ff);
  c_cal_done: cover property (cal_done);
  c_internal_osc: cover property (osc_internal_ff && conv_done);

endmodule : sarcs_seq

// [tb/sarcs_host_model.sv]
/*
  host side of the sequencer: master clock pin, hold pulses, sampled input and comparators.
  assumes ref_clk at 100 MHz and the bench calling pulse_hold.
*/
`timescale 1ns/1ns

module sarcs_host_model (
  input wire logic ref_clk,
  input wire logic pin_run,
  input wire logic [11:0] analog_input,
  input wire logic tracking,
  input wire logic [11:0] trial,
  input wire logic [5:0] trim,
  output logic master_clock_pin,
  output logic hold_n,
  output logic cmp_below,
  output logic cal_cmp_heavy
);
  logic [1:0] div_ff = 2'h0;
  logic [11:0] held_ff = 12'h000;

  initial hold_n = 1'b1;

  // pin held low selects the internal oscillator
  assign master_clock_pin = pin_run & div_ff[1];
  assign cmp_below = held_ff < trial;
  assign cal_cmp_heavy = trim > 6'h1D;

  always @(posedge ref_clk) begin
    div_ff <= div_ff + 2'h1;
    // the array follows the input only while tracking
    if (tracking) begin
      held_ff <= analog_input;
    end
  end

  // low for n ref cycles; the caller gives one master period plus 50 ns, with margin
  task automatic pulse_hold(input int n);
    @(posedge ref_clk);
    #1 hold_n = 1'b0;
    repeat (n) @(posedge ref_clk);
    #1 hold_n = 1'b1;
  endtask : pulse_hold
endmodule : sarcs_host_model

// [tb/sarcs_seq_tb_top.sv]
/*
  self-checking bench of the conversion sequencer.
  assumes the host model drives the pin, hold and comparators.
*/
`timescale 1ns/1ns

module sarcs_seq_tb_top;
  import sarcs_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic pin_run = 1'b1;
  logic [11:0] analog_input = 12'h000;
  logic over = 1'b0;
  logic under = 1'b0;
  logic bipolar = 1'b0;
  logic cal_start = 1'b0;
  logic master_clock_pin, hold_n, cmp_below, cal_cmp_heavy;
  logic [11:0] trial_code_ff, result_code_ff;
  logic result_valid_ff, tracking_ff, converting_ff, calibrating_ff, osc_internal_ff, msb_to_ref_ff;
  logic [3:0] cal_bit_ff;
  logic [5:0] cal_trim_ff;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc;

  sarcs_seq sarcs_seq_i (.ref_clk(ref_clk), .nrst(nrst), .master_clock_pin(master_clock_pin),
    .hold_n(hold_n), .cmp_below(cmp_below), .ain_over_ref(over), .ain_under_range(under),
    .bipolar_mode(bipolar), .cal_start(cal_start), .cal_cmp_heavy(cal_cmp_heavy),
    .trial_code_ff(trial_code_ff), .result_code_ff(result_code_ff), .result_valid_ff(result_valid_ff),
    .tracking_ff(tracking_ff), .converting_ff(converting_ff), .calibrating_ff(calibrating_ff),
    .osc_internal_ff(osc_internal_ff), .msb_to_ref_ff(msb_to_ref_ff), .cal_bit_ff(cal_bit_ff),
    .cal_trim_ff(cal_trim_ff));

  sarcs_host_model host_i (.ref_clk(ref_clk), .pin_run(pin_run), .analog_input(analog_input), .tracking(tracking_ff),
    .trial(trial_code_ff), .trim(cal_trim_ff), .master_clock_pin(master_clock_pin), .hold_n(hold_n),
    .cmp_below(cmp_below), .cal_cmp_heavy(cal_cmp_heavy));

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk_code(input string what, input logic [11:0] exp, input logic [11:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_code

  task automatic chk_flag(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_flag

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step

  // one conversion; tck is ref cycles per master tick; poke disturbs input and hold once it runs
  task automatic convert(input logic [11:0] v, input logic poke, input int tck);
    analog_input = v;
    cyc = 0;
    fork
      host_i.pulse_hold(tck + 8);
    join_none
    while (converting_ff !== 1'b1 && cyc < 3000) begin
      step(1);
      cyc++;
    end
    chk_flag("tracking left", 1'b0, tracking_ff);
    chk_flag("msb off in hold", 1'b0, msb_to_ref_ff);
    // alignment ends within four ticks and the first decision comes four ticks after it
    step(4 * tck);
    cyc += 4 * tck;
    chk_code("trial at start", 12'h800, trial_code_ff);
    if (poke) begin
      analog_input = ~v;
      over = 1'b1;
      // the first pulse is over by now, so this is a fresh fall in mid-conversion
      fork
        host_i.pulse_hold(tck + 8);
      join_none
    end
    while (result_valid_ff !== 1'b1 && cyc < 3000) begin
      step(1);
      cyc++;
    end
    chk_flag("result valid", 1'b1, result_valid_ff);
    step(1);
    chk_flag("valid pulse", 1'b0, result_valid_ff);
    chk_flag("tracking back", 1'b1, tracking_ff);
  endtask : convert

  task automatic t_codes();
    logic [11:0] tbl [7] = '{12'hA5C, 12'h001, 12'hFFE, 12'h800, 12'h7FF, 12'h000, 12'hFFF};
    foreach (tbl[k]) begin
      convert(tbl[k], 1'b0, 4);
      chk_code("result", tbl[k], result_code_ff);
      chk_flag("conv time", 1'b1, cyc >= 4 * 49 && cyc <= 4 * 54 + 8);
    end
  endtask : t_codes

  task automatic t_sat();
    logic [1:0] fl [3] = '{2'b10, 2'b01, 2'b11};
    logic [11:0] ex [3] = '{12'hFFF, 12'h000, 12'hFFF};
    foreach (fl[k]) begin
      over = fl[k][1];
      under = fl[k][0];
      convert(12'h5A3, 1'b0, 4);
      chk_code("saturated", ex[k], result_code_ff);
    end
    over = 1'b0;
    under = 1'b0;
  endtask : t_sat

  task automatic t_ignore();
    convert(12'h456, 1'b1, 4);
    over = 1'b0;
    chk_code("held value", 12'h456, result_code_ff);
    step(20);
    chk_flag("second hold", 1'b0, converting_ff);
  endtask : t_ignore

  task automatic t_bipolar();
    bipolar = 1'b1;
    step(2);
    chk_flag("msb to ref", 1'b1, msb_to_ref_ff);
    convert(12'h800, 1'b0, 4);
    chk_code("mid scale", 12'h800, result_code_ff);
    step(1);
    chk_flag("msb to ref again", 1'b1, msb_to_ref_ff);
    bipolar = 1'b0;
    step(2);
  endtask : t_bipolar

  task automatic t_osc();
    pin_run = 1'b0;
    step(210);
    chk_flag("osc internal", 1'b1, osc_internal_ff);
    convert(12'h3C3, 1'b0, 25);
    chk_code("osc result", 12'h3C3, result_code_ff);
    chk_flag("osc conv time", 1'b1, cyc >= 25 * 49 && cyc <= 25 * 54 + 30);
    pin_run = 1'b1;
    step(4);
    chk_flag("osc external", 1'b0, osc_internal_ff);
  endtask : t_osc

  task automatic t_cal();
    cal_start = 1'b1;
    step(1);
    cal_start = 1'b0;
    step(1);
    chk_flag("calibrating", 1'b1, calibrating_ff);
    host_i.pulse_hold(12);
    step(8);
    chk_flag("hold in cal", 1'b0, converting_ff);
    cyc = 0;
    while (calibrating_ff !== 1'b0 && cyc < 20000) begin
      step(1);
      cyc++;
    end
    chk_flag("cal done", 1'b0, calibrating_ff);
    step(1);
    chk_flag("tracking idle", 1'b1, tracking_ff);
    // the model's weight turns light at 1D, so every bit walks down from 20 and settles there
    chk_code("trim bit 0", 12'h01D, {6'h00, cal_trim_ff});
    chk_code("cal bit back", 12'h000, {8'h00, cal_bit_ff});
  endtask : t_cal

  task automatic finish_test();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  initial begin
    step(4);
    nrst = 1'b1;
    step(1);
    chk_flag("reset tracking", 1'b1, tracking_ff);
    chk_code("reset result", 12'h000, result_code_ff);
    t_codes();
    t_sat();
    t_ignore();
    t_bipolar();
    t_osc();
    t_cal();
    finish_test();
  end

  // the whole sequence needs well under 30000 cycles
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_mismatch++;
    finish_test();
  end
endmodule : sarcs_seq_tb_top
